// ---- core/ccs_pkg.sv ----
// package of constants and types for the cpu register and context stack
package ccs_pkg;
	// data and program widths
	localparam int CCS_DW = 8;
	localparam int CCS_PC_W = 12;
	localparam int CCS_OFF_W = 8;
	// return stack levels
	localparam int CCS_STACK_LEVELS = 6;
	localparam int CCS_DEPTH_W = 3;
	// data-space locations of the mirrored registers
	localparam logic [7:0] CCS_ADDR_PTR1 = 8'h80;
	localparam logic [7:0] CCS_ADDR_PTR2 = 8'h81;
	localparam logic [7:0] CCS_ADDR_SD1 = 8'h82;
	localparam logic [7:0] CCS_ADDR_SD2 = 8'h83;
	localparam logic [7:0] CCS_ADDR_ACC = 8'hFF;
	// reset values
	localparam logic [7:0] CCS_REG_RST = 8'h00;
	localparam logic [11:0] CCS_PC_RESET_VEC = 12'h000;
	localparam logic [7:0] CCS_RDATA_IDLE = 8'h00;
	localparam logic CCS_FLAG_RST = 1'b0;
	// program counter update requests from the sequencer
	typedef enum logic [3:0] {
		CCS_PC_HOLD,
		CCS_PC_INC,
		CCS_PC_REL,
		CCS_PC_JUMP,
		CCS_PC_CALL,
		CCS_PC_INT,
		CCS_PC_NMI,
		CCS_PC_RET,
		CCS_PC_INTERRUPT_EXIT,
		CCS_PC_RESET
	} ccs_pc_op_t;
	// execution contexts, each owning one carry/zero pair
	typedef enum logic [1:0] {
		CCS_CTX_NORMAL,
		CCS_CTX_INT,
		CCS_CTX_NMI
	} ccs_ctx_t;
endpackage

// ---- core/ccs_return_stack.sv ----
// six-level shifting return address stack with saturating depth
`timescale 1ns/1ns
`default_nettype none
module ccs_return_stack #(
	parameter int LEVELS = ccs_pkg::CCS_STACK_LEVELS,
	parameter int W = ccs_pkg::CCS_PC_W,
	parameter int DW = ccs_pkg::CCS_DEPTH_W
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire logic i_push,
	input wire logic i_pop,
	input wire logic [W-1:0] i_push_data,
	output logic [W-1:0] o_top,
	output logic o_empty,
	output logic [DW-1:0] o_depth
);
	import ccs_pkg::*;

	typedef struct packed {
		logic [LEVELS-1:0][W-1:0] level;
		logic [DW-1:0] depth;
	} ccs_stack_state_t;

	ccs_stack_state_t q;
	ccs_stack_state_t next_q;

	localparam logic [DW-1:0] FULL = DW'(LEVELS);

	// push shifts every level deeper, pop shifts every level up
	always_comb begin
		next_q = q;
		if (i_push) begin
			next_q.level[0] = i_push_data; // RL14
			for (int i = 1; i < LEVELS; i++) begin
				next_q.level[i] = q.level[i-1]; // RL14
			end
			if (q.depth != FULL) begin
				next_q.depth = q.depth + 1'b1; // RL16
			end
		end else if (i_pop && q.depth != '0) begin
			for (int i = 0; i < LEVELS - 1; i++) begin
				next_q.level[i] = q.level[i+1]; // RL15
			end
			next_q.depth = q.depth - 1'b1; // RL16
		end
	end

	// state register
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign o_top = q.level[0];
	assign o_empty = (q.depth == '0);
	assign o_depth = q.depth;
endmodule
`default_nettype wire

// ---- core/ccs_core_regs.sv ----
// programmer-visible registers, program counter, flag contexts and stack of the core
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [RL1] working register is 8 bits, also data-space location FFh
// [RL2] two pointer registers at data-space 80h and 81h, read and write
// [RL3] two short direct registers at data-space 82h and 83h
// [RL4] program counter is 12 bits, reaching 4096 bytes
// [RL5] ordinary instruction advances program counter by one
// [RL6] relative branch adds signed offset to program counter
// [RL7] jump, call, vector and popped return address load program counter
// [RL8] three carry/zero pairs: normal, interrupt, non-maskable
// [RL9] entry switches to that context's pair; interrupt exit restores previous pair; code switches to the interrupt pair from the normal context only
// [RL10] pairs keep values across switches; only active pair is written
// [RL11] active carry takes arithmetic carry or tested bit; feeds rotate left
// [RL12] active zero set when latest result is zero
// [RL13] after reset the non-maskable context and pair are active
// [RL14] call or interrupt pushes program counter; sixth level lost
// [RL15] return pops level one into program counter, deeper levels move up
// [RL16] stack saturates when full; return on empty stack just continues
// [RL17] software saves working and data-space registers itself
// [RL18] context record remembers prior context for nested exits
module ccs_core_regs #(
	parameter logic [11:0] RESET_VEC = ccs_pkg::CCS_PC_RESET_VEC
) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire ccs_pkg::ccs_pc_op_t i_pc_op,
	input wire logic [ccs_pkg::CCS_PC_W-1:0] i_target,
	input wire logic [ccs_pkg::CCS_OFF_W-1:0] i_rel_offset,
	input wire logic i_acc_we,
	input wire logic [ccs_pkg::CCS_DW-1:0] i_acc_wdata,
	input wire logic i_c_we,
	input wire logic i_c_val,
	input wire logic i_z_we,
	input wire logic [ccs_pkg::CCS_DW-1:0] i_result,
	input wire logic i_ds_rd,
	input wire logic i_ds_wr,
	input wire logic [7:0] i_ds_addr,
	input wire logic [ccs_pkg::CCS_DW-1:0] i_ds_wdata,
	output logic [ccs_pkg::CCS_DW-1:0] o_ds_rdata,
	output logic o_ds_hit,
	output logic [ccs_pkg::CCS_DW-1:0] o_acc,
	output logic [ccs_pkg::CCS_DW-1:0] o_ptr1,
	output logic [ccs_pkg::CCS_DW-1:0] o_ptr2,
	output logic [ccs_pkg::CCS_DW-1:0] o_sd1,
	output logic [ccs_pkg::CCS_DW-1:0] o_sd2,
	output logic [ccs_pkg::CCS_PC_W-1:0] o_pc,
	output logic o_carry,
	output logic o_zero,
	output ccs_pkg::ccs_ctx_t o_ctx,
	output logic [ccs_pkg::CCS_DEPTH_W-1:0] o_stack_depth
);
	import ccs_pkg::*;

	typedef struct packed {
		logic [CCS_DW-1:0] acc;
		logic [CCS_DW-1:0] ptr1;
		logic [CCS_DW-1:0] ptr2;
		logic [CCS_DW-1:0] sd1;
		logic [CCS_DW-1:0] sd2;
		logic [CCS_PC_W-1:0] pc;
		logic [2:0] carry;
		logic [2:0] zero;
		ccs_ctx_t ctx;
		ccs_ctx_t prev;
		logic act_c;
		logic act_z;
		logic [CCS_DW-1:0] rdata;
		logic hit;
	} ccs_core_state_t;

	ccs_core_state_t q;
	ccs_core_state_t next_q;

	// stack handshake
	logic push;
	logic pop;
	logic [CCS_PC_W-1:0] stk_top;
	logic stk_empty;
	logic [CCS_PC_W-1:0] rel_ext;
	logic is_exit;
	logic is_entry;

	// requests that move the return stack
	assign is_entry = (i_pc_op == CCS_PC_CALL) || (i_pc_op == CCS_PC_INT)
		|| (i_pc_op == CCS_PC_NMI);
	assign is_exit = (i_pc_op == CCS_PC_RET) || (i_pc_op == CCS_PC_INTERRUPT_EXIT);
	assign push = is_entry; // RL14
	assign pop = is_exit; // RL15

	// sign-extend the branch offset to program counter width
	assign rel_ext = {{(CCS_PC_W - CCS_OFF_W){i_rel_offset[CCS_OFF_W-1]}}, i_rel_offset};

	// return address stack
	ccs_return_stack #(
		.LEVELS(CCS_STACK_LEVELS),
		.W(CCS_PC_W),
		.DW(CCS_DEPTH_W)
	) u_stack (
		.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b),
		.i_push(push),
		.i_pop(pop),
		.i_push_data(q.pc),
		.o_top(stk_top),
		.o_empty(stk_empty),
		.o_depth(o_stack_depth)
	);

	// next state of every register of the core
	always_comb begin
		next_q = q;

		// data-space writes to the mirrored registers
		if (i_ds_wr) begin
			if (i_ds_addr == CCS_ADDR_PTR1) begin
				next_q.ptr1 = i_ds_wdata; // RL2
			end else if (i_ds_addr == CCS_ADDR_PTR2) begin
				next_q.ptr2 = i_ds_wdata; // RL2
			end else if (i_ds_addr == CCS_ADDR_SD1) begin
				next_q.sd1 = i_ds_wdata; // RL3
			end else if (i_ds_addr == CCS_ADDR_SD2) begin
				next_q.sd2 = i_ds_wdata; // RL3
			end else if (i_ds_addr == CCS_ADDR_ACC) begin
				next_q.acc = i_ds_wdata; // RL1
			end
		end

		// alu result into the working register wins over a bus write
		if (i_acc_we) begin
			next_q.acc = i_acc_wdata; // RL1
		end

		// data-space reads answer one cycle later
		next_q.hit = 1'b0;
		next_q.rdata = CCS_RDATA_IDLE;
		if (i_ds_rd) begin
			if (i_ds_addr == CCS_ADDR_PTR1) begin
				next_q.hit = 1'b1;
				next_q.rdata = q.ptr1; // RL2
			end else if (i_ds_addr == CCS_ADDR_PTR2) begin
				next_q.hit = 1'b1;
				next_q.rdata = q.ptr2; // RL2
			end else if (i_ds_addr == CCS_ADDR_SD1) begin
				next_q.hit = 1'b1;
				next_q.rdata = q.sd1; // RL3
			end else if (i_ds_addr == CCS_ADDR_SD2) begin
				next_q.hit = 1'b1;
				next_q.rdata = q.sd2; // RL3
			end else if (i_ds_addr == CCS_ADDR_ACC) begin
				next_q.hit = 1'b1;
				next_q.rdata = q.acc; // RL1
			end
		end

		// flag writes land only in the pair of the running context
		if (i_c_we) begin
			next_q.carry[q.ctx] = i_c_val; // RL10 RL11
		end
		if (i_z_we) begin
			next_q.zero[q.ctx] = (i_result == '0); // RL10 RL12
		end

		// program counter update
		case (i_pc_op)
			CCS_PC_INC: begin
				next_q.pc = q.pc + 1'b1; // RL5
			end
			CCS_PC_REL: begin
				next_q.pc = q.pc + rel_ext; // RL6
			end
			CCS_PC_JUMP: begin
				next_q.pc = i_target; // RL7
			end
			CCS_PC_CALL: begin
				next_q.pc = i_target; // RL7
			end
			CCS_PC_INT: begin
				next_q.pc = i_target; // RL7
				// the switch to the interrupt pair happens from the main routine only
				if (q.ctx == CCS_CTX_NORMAL) begin
					next_q.prev = q.ctx; // RL18
					next_q.ctx = CCS_CTX_INT; // RL9
				end
			end
			CCS_PC_NMI: begin
				next_q.pc = i_target; // RL7
				if (q.ctx != CCS_CTX_NMI) begin
					next_q.prev = q.ctx; // RL18
					next_q.ctx = CCS_CTX_NMI; // RL9
				end
			end
			CCS_PC_RET: begin
				// an empty stack leaves pc unchanged
				if (!stk_empty) begin
					next_q.pc = stk_top; // RL15 RL7
				end
			end
			CCS_PC_INTERRUPT_EXIT: begin
				if (!stk_empty) begin
					next_q.pc = stk_top; // RL15 RL7
				end
				// restore the pair that was in use before entry
				if (q.ctx == CCS_CTX_NMI) begin
					next_q.ctx = q.prev; // RL9 RL18
					next_q.prev = CCS_CTX_NORMAL;
				end else begin
					next_q.ctx = CCS_CTX_NORMAL; // RL9
					next_q.prev = CCS_CTX_NORMAL;
				end
			end
			CCS_PC_RESET: begin
				next_q.pc = RESET_VEC; // RL7
				next_q.ctx = CCS_CTX_NMI; // RL13
				next_q.prev = CCS_CTX_NORMAL;
			end
			default: begin
				next_q.pc = q.pc;
			end
		endcase

		// active pair follows the context after any switch
		next_q.act_c = next_q.carry[next_q.ctx]; // RL8 RL9
		next_q.act_z = next_q.zero[next_q.ctx]; // RL8 RL9
	end

	// state register; reset enters the non-maskable context
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q.acc <= CCS_REG_RST;
			q.ptr1 <= CCS_REG_RST;
			q.ptr2 <= CCS_REG_RST;
			q.sd1 <= CCS_REG_RST;
			q.sd2 <= CCS_REG_RST;
			q.pc <= RESET_VEC; // RL7
			q.carry <= {3{CCS_FLAG_RST}};
			q.zero <= {3{CCS_FLAG_RST}};
			q.ctx <= CCS_CTX_NMI; // RL13
			q.prev <= CCS_CTX_NORMAL;
			q.act_c <= CCS_FLAG_RST;
			q.act_z <= CCS_FLAG_RST;
			q.rdata <= CCS_RDATA_IDLE;
			q.hit <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	// outputs straight from the state flops
	assign o_acc = q.acc;
	assign o_ptr1 = q.ptr1;
	assign o_ptr2 = q.ptr2;
	assign o_sd1 = q.sd1;
	assign o_sd2 = q.sd2;
	assign o_pc = q.pc; // RL4
	assign o_carry = q.act_c; // RL11
	assign o_zero = q.act_z; // RL12
	assign o_ctx = q.ctx;
	assign o_ds_rdata = q.rdata;
	assign o_ds_hit = q.hit;
endmodule
`default_nettype wire

// ---- sim/ccs_core_regs_monitor.sv ----
// assertion checker for the core register and context block
`timescale 1ns/1ns
`default_nettype none
module ccs_core_regs_monitor
	import ccs_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input wire ccs_pkg::ccs_pc_op_t i_pc_op,
	input wire logic [11:0] i_target,
	input wire logic [7:0] i_rel_offset,
	input wire logic i_c_we,
	input wire logic i_c_val,
	input wire logic i_z_we,
	input wire logic [7:0] i_result,
	input wire logic i_ds_rd,
	input wire logic [7:0] i_ds_addr,
	input wire logic o_ds_hit,
	input wire logic [11:0] o_pc,
	input wire logic o_carry,
	input wire logic o_zero,
	input wire ccs_pkg::ccs_ctx_t o_ctx,
	input wire logic [2:0] o_stack_depth
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	// program counter updates
	a_inc_pc: assert property (
		i_pc_op == CCS_PC_INC |=> o_pc == $past(o_pc) + 12'h001) else $error("pc not plus one");
	a_rel_add: assert property (
		i_pc_op == CCS_PC_REL |=> o_pc == $past(o_pc) + {{4{$past(i_rel_offset[7])}},
		$past(i_rel_offset)}) else $error("relative branch sum wrong");
	a_hold_pc: assert property (
		i_pc_op == CCS_PC_HOLD |=> $stable(o_pc)) else $error("pc moved on hold");
	a_nmi_entry: assert property (
		i_pc_op == CCS_PC_NMI |=> o_ctx == CCS_CTX_NMI && o_pc == $past(i_target))
		else $error("nmi entry wrong");
	a_reset_ctx: assert property (
		i_pc_op == CCS_PC_RESET |=> o_ctx == CCS_CTX_NMI) else $error("reset op context wrong");
	// stack depth
	a_push_depth: assert property (
		i_pc_op == CCS_PC_CALL && o_stack_depth < 3'h6 |=> o_stack_depth == $past(o_stack_depth)
		+ 3'h1) else $error("push depth wrong");
	a_full_sat: assert property (
		i_pc_op == CCS_PC_CALL && o_stack_depth == 3'h6 |=> o_stack_depth == 3'h6)
		else $error("full stack depth moved");
	a_ret_empty: assert property (
		i_pc_op == CCS_PC_RET && o_stack_depth == 3'h0 |=> $stable(o_pc) && o_stack_depth == 3'h0)
		else $error("empty return moved pc");
	// flags and data-space decode
	a_carry_wr: assert property (
		i_c_we && i_pc_op == CCS_PC_HOLD |=> o_carry == $past(i_c_val)) else $error("carry wrong");
	a_zero_wr: assert property (
		i_z_we && i_pc_op == CCS_PC_HOLD |=> o_zero == ($past(i_result) == 8'h00))
		else $error("zero flag wrong");
	a_ds_hit: assert property (
		1'b1 |=> o_ds_hit == ($past(i_ds_rd) && ($past(i_ds_addr) inside {8'h80, 8'h81, 8'h82,
		8'h83, 8'hFF}))) else $error("data-space hit wrong");
endmodule
bind ccs_core_regs ccs_core_regs_monitor u_mon (.i_core_clk, .i_rst_b, .i_pc_op, .i_target,
	.i_rel_offset, .i_c_we, .i_c_val, .i_z_we, .i_result, .i_ds_rd, .i_ds_addr, .o_ds_hit,
	.o_pc, .o_carry, .o_zero, .o_ctx, .o_stack_depth);
`default_nettype wire

// ---- sim/ccs_ds_model.sv ----
// data-space master standing in for the core load and store path
`timescale 1ns/1ns
`default_nettype none
module ccs_ds_model (
	input wire logic i_core_clk,
	input wire logic [7:0] i_rdata,
	output logic o_rd,
	output logic o_wr,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	// idle bus at start
	initial begin
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// one byte per call; callers keep their own register copies
	task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge i_core_clk);
		o_wr = w;
		o_rd = !w;
		o_addr = a;
		o_wdata = d;
		@(negedge i_core_clk);
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_addr = ~a;
		o_wdata = ~d;
		q = i_rdata;
	endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// testbench for the core register and context block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import ccs_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	ccs_pc_op_t op = CCS_PC_HOLD;
	logic [11:0] tgt = 12'h000;
	logic [7:0] off = 8'h00;
	logic [7:0] res = 8'h01;
	logic [7:0] wd = 8'h00;
	logic awe = 1'b0;
	logic cwe = 1'b0;
	logic cv = 1'b0;
	logic zwe = 1'b0;
	logic rd, wr, c, z, hit;
	logic [7:0] ad, dw, rdat, acc, p1, p2, s1, s2;
	logic [11:0] pc;
	logic [2:0] dep;
	ccs_ctx_t ctx;
	int miscompares = 0;
	int cmp_count = 0;
	ccs_core_regs u_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_pc_op(op), .i_target(tgt),
		.i_rel_offset(off), .i_acc_we(awe), .i_acc_wdata(wd), .i_c_we(cwe), .i_c_val(cv),
		.i_z_we(zwe), .i_result(res), .i_ds_rd(rd), .i_ds_wr(wr), .i_ds_addr(ad),
		.i_ds_wdata(dw), .o_ds_rdata(rdat), .o_ds_hit(hit), .o_acc(acc), .o_ptr1(p1),
		.o_ptr2(p2), .o_sd1(s1), .o_sd2(s2), .o_pc(pc), .o_carry(c), .o_zero(z), .o_ctx(ctx),
		.o_stack_depth(dep));
	ccs_ds_model u_ds (.i_core_clk(clk), .i_rdata(rdat), .o_rd(rd), .o_wr(wr), .o_addr(ad),
		.o_wdata(dw));
	// 25 MHz core clock
	initial begin
		forever #20 clk = ~clk;
	end
	// compare and count
	task automatic chk(input string n, input logic [11:0] s, e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// context and flag pair check
	task automatic cf(input logic [1:0] x, input logic cc, zz);
		chk("ctx", 12'(ctx), 12'(x));
		chk("carry", 12'(c), 12'(cc));
		chk("zero", 12'(z), 12'(zz));
	endtask
	// one pc request, then hold
	task automatic go(input ccs_pc_op_t o, input logic [11:0] t);
		@(negedge clk);
		op = o;
		tgt = t;
		@(negedge clk);
		op = CCS_PC_HOLD;
	endtask
	// write carry and zero of the running context
	task automatic flg(input logic v, input logic [7:0] r);
		@(negedge clk);
		cwe = 1'b1;
		cv = v;
		zwe = 1'b1;
		res = r;
		@(negedge clk);
		cwe = 1'b0;
		zwe = 1'b0;
	endtask
	task automatic t_reset();
		cf(2'd2, 1'b0, 1'b0);
		chk("pc", pc, 12'h000);
		chk("depth", 12'(dep), 12'h000);
		$display("test reset done");
	endtask
	task automatic t_regs();
		logic [7:0] q;
		logic [7:0] a [6] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF, 8'h90};
		for (int i = 0; i < 6; i++) begin
			u_ds.xfer(1'b1, a[i], a[i] ^ 8'h5A, q);
			u_ds.xfer(1'b0, a[i], 8'h00, q);
			chk("rdata", 12'(q), (i < 5) ? 12'(a[i] ^ 8'h5A) : 12'h000);
			chk("hit", 12'(hit), (i < 5) ? 12'h001 : 12'h000);
		end
		chk("ptr1", 12'(p1), 12'h0DA);
		chk("ptr2", 12'(p2), 12'h0DB);
		chk("sd1", 12'(s1), 12'h0D8);
		chk("sd2", 12'(s2), 12'h0D9);
		@(negedge clk);
		awe = 1'b1;
		wd = 8'hC3;
		@(negedge clk);
		awe = 1'b0;
		chk("acc", 12'(acc), 12'h0C3);
		$display("test regs done");
	endtask
	task automatic t_pc();
		go(CCS_PC_JUMP, 12'hFFF);
		go(CCS_PC_INC, 12'h000);
		chk("pc_wrap", pc, 12'h000);
		go(CCS_PC_JUMP, 12'h101);
		chk("jump", pc, 12'h101);
		off = 8'hF0;
		go(CCS_PC_REL, 12'h000);
		chk("rel_back", pc, 12'h0F1);
		off = 8'h7F;
		go(CCS_PC_REL, 12'h000);
		chk("rel_fwd", pc, 12'h170);
		go(CCS_PC_CALL, 12'h800);
		chk("call", pc, 12'h800);
		go(CCS_PC_RET, 12'h000);
		chk("ret", pc, 12'h170);
		$display("test pc done");
	endtask
	task automatic t_stack();
		go(CCS_PC_JUMP, 12'h001);
		for (int i = 1; i <= 7; i++) begin
			go(CCS_PC_CALL, 12'(i * 16));
		end
		chk("depth_full", 12'(dep), 12'h006);
		for (int i = 6; i >= 1; i--) begin
			go(CCS_PC_RET, 12'h000);
			chk("pop_pc", pc, 12'(i * 16));
		end
		go(CCS_PC_RET, 12'h000);
		chk("empty_pc", pc, 12'h010);
		chk("empty_depth", 12'(dep), 12'h000);
		$display("test stack done");
	endtask
	task automatic t_flags();
		flg(1'b1, 8'h00);
		cf(2'd2, 1'b1, 1'b1);
		go(CCS_PC_INTERRUPT_EXIT, 12'h000);
		cf(2'd0, 1'b0, 1'b0);
		flg(1'b1, 8'h05);
		cf(2'd0, 1'b1, 1'b0);
		go(CCS_PC_INT, 12'h004);
		cf(2'd1, 1'b0, 1'b0);
		flg(1'b0, 8'h00);
		go(CCS_PC_NMI, 12'h008);
		cf(2'd2, 1'b1, 1'b1);
		go(CCS_PC_INTERRUPT_EXIT, 12'h000);
		cf(2'd1, 1'b0, 1'b1);
		go(CCS_PC_INTERRUPT_EXIT, 12'h000);
		cf(2'd0, 1'b1, 1'b0);
		go(CCS_PC_RESET, 12'h000);
		chk("rst_ctx", 12'(ctx), 12'h002);
		chk("rst_pc", pc, 12'h000);
		$display("test flags done");
	endtask
	// verdict and end of run
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		t_reset();
		t_regs();
		t_pc();
		t_stack();
		t_flags();
		end_of_test();
	end
	// hang limit
	initial begin
		#400000;
		miscompares++;
		end_of_test();
	end
endmodule
`default_nettype wire
